// ### inc/burst_pkg.sv
package burst_pkg;

   // ----------------------------------------
   // Clock and carrier figures, mHz units
   // ----------------------------------------
   localparam logic [35:0] CLK_MHZ_UNITS   = 36'hBA43B7400;   // 50 MHz clock in mHz
   localparam logic [33:0] FREQ_MIN        = 34'h00000000A;   // 10 mHz
   localparam logic [33:0] FREQ_MAX_STD    = 34'h12A05F200;   // 5 MHz
   localparam logic [33:0] FREQ_MAX_TRI    = 34'h005F5E100;   // 100 kHz
   localparam logic [33:0] FREQ_STEP_BAND  = 34'h03B9ACA00;   // 1 MHz band
   localparam logic [33:0] FREQ_LOW_REGION = 34'h0000186A0;   // 100 Hz
   localparam logic [33:0] FREQ_DEFAULT    = 34'h0000F4240;   // 1 kHz
   localparam logic [2:0]  SECONDS_SHIFT   = 3'h1;            // count/500 s in mHz = count*2

   // ----------------------------------------
   // Burst count, phase and rate limits
   // ----------------------------------------
   localparam logic [15:0] COUNT_MIN       = 16'h0001;
   localparam logic [15:0] COUNT_MAX       = 16'hC350;        // 50000
   localparam logic [15:0] COUNT_DEFAULT   = 16'h0001;
   localparam logic [15:0] COUNT_FULL_BAND = 16'h0005;
   localparam logic signed [19:0] PHASE_MAX     = 20'sh57E40; // +360000 mdeg
   localparam logic signed [19:0] PHASE_MIN     = -20'sh57E40;
   localparam logic signed [19:0] PHASE_DEFAULT = 20'sh00000;
   localparam logic [25:0] RATE_MIN        = 26'h000000A;     // 10 mHz
   localparam logic [25:0] RATE_MAX        = 26'h2FAF080;     // 50 kHz
   localparam logic [25:0] RATE_DEFAULT    = 26'h00186A0;     // 100 Hz

   // ----------------------------------------
   // Selection codes
   // ----------------------------------------
   localparam logic [2:0] SHAPE_SINE     = 3'h0;
   localparam logic [2:0] SHAPE_SQUARE   = 3'h1;
   localparam logic [2:0] SHAPE_TRIANGLE = 3'h2;
   localparam logic [2:0] SHAPE_RAMP     = 3'h3;
   localparam logic [2:0] SHAPE_ARB      = 3'h4;
   localparam logic [1:0] TRIG_IMM       = 2'h0;
   localparam logic [1:0] TRIG_EXT       = 2'h1;
   localparam logic [1:0] TRIG_BUS       = 2'h2;
   localparam logic       ORIGIN_INT     = 1'b0;
   localparam logic       ORIGIN_EXT     = 1'b1;
   localparam logic       ENABLE_DEFAULT = 1'b1;
   localparam int         OPC_BIT        = 0;

   typedef enum logic [0:0] {ST_IDLE, ST_RUN} burst_state_t;

endpackage

// ### inc/trig_sync_if.sv
interface trig_sync_if;
   logic level;
   logic rise;
   modport src (output level, output rise);
   modport dst (input level, input rise);
endinterface

// ### design/trig_input_sync.sv
module trig_input_sync (
   input  wire logic  i_clk,
   input  wire logic  i_arst_n,
   input  wire logic  i_pin,
   trig_sync_if.src   sync
);

   logic s1;
   logic s2;
   logic s3;

   // ----------------------------------------
   // Three-stage synchroniser, agree filter
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= i_pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sync.level <= 1'b0;
         sync.rise  <= 1'b0;
      end else begin
         sync.rise <= 1'b0;
         if (s2 == s3 && s3 != sync.level) begin
            sync.level <= s3;
            sync.rise  <= s3;
         end
      end
   end

endmodule

// ### design/burst_modulation_controller.sv
// What this block does
// RULE1: burst count 1 to 50000, default one
// RULE2: minimum count grows per megahertz band
// RULE3: too-high carrier lowered, remote conflict flagged
// RULE4: count over frequency at most 500 s
// RULE5: carrier held within 10 mHz to limit
// RULE6: start phase +-360 degrees, default zero
// RULE7: zero phase is rising crossing or sample
// RULE8: internal repeat rate 10 mHz to 50 kHz
// RULE9: rate used only for immediate triggering
// RULE10: too-fast rate gives back-to-back bursts
// RULE11: gate high gives continuous output, low rests
// RULE12: gated mode ignores count, rate, phase, source
// RULE13: origin defaults internal, internal disables gating
// RULE14: enabling burst turns other modulation off
// RULE15: each trigger gives exactly count cycles
// RULE16: trigger defaults immediate, setup forces immediate
// RULE17: one burst per external rising edge, waiting
// RULE18: one burst per bus trigger command
// RULE19: wait command holds until bursts finish; with immediate triggering the code holds for one cycle only
// RULE20: completion answers query or sets bit 0
// RULE21: report enable, origin and trigger codes
// RULE22: power-up in internally triggered burst
// RULE23: external input synchronised, rising edge detected
module burst_modulation_controller
   import burst_pkg::*;
(
   input  wire logic               I_CLK,
   input  wire logic               I_ARST_N,
   input  wire logic               I_CFG_WRITE,
   input  wire logic [15:0]        I_CYCLES_PER_BURST_SETTING,
   input  wire logic signed [19:0] I_START_PHASE_SETTING,
   input  wire logic [25:0]        I_INTERNAL_REPEAT_RATE_SETTING,
   input  wire logic               I_BURST_ORIGIN_SELECT,
   input  wire logic [1:0]         I_TRIGGER_ORIGIN_SELECT,
   input  wire logic               I_BURST_ENABLE_SETTING,
   input  wire logic               I_APPLY_STB,
   input  wire logic               I_FREQ_REQ_STB,
   input  wire logic [33:0]        I_FREQ_REQ,
   input  wire logic               I_FREQ_REQ_REMOTE,
   input  wire logic [2:0]         I_CARRIER_SHAPE,
   input  wire logic               I_CARRIER_WRAP,
   input  wire logic               I_EXT_TRIG,
   input  wire logic               I_BUS_TRIGGER,
   input  wire logic               I_WAI_STB,
   input  wire logic               I_OPC_QUERY_STB,
   input  wire logic               I_OPC_CMD_STB,
   input  wire logic               I_OPC_FLAG_CLEAR,
   output logic                    O_CARRIER_ON,
   output logic                    O_PHASE_LOAD,
   output logic signed [19:0]      O_START_PHASE,
   output logic                    O_PHASE_FROM_FIRST_SAMPLE,
   output logic [33:0]             O_CARRIER_FREQ,
   output logic                    O_SETTINGS_CONFLICT,
   output logic                    O_OTHER_MOD_OFF,
   output logic                    O_TRIG_WAIT,
   output logic                    O_BURST_DONE,
   output logic                    O_CMD_HOLD,
   output logic                    O_OPC_REPLY,
   output logic                    O_OPC_FLAG,
   output logic [15:0]             O_CYCLES_PER_BURST,
   output logic [25:0]             O_INTERNAL_REPEAT_RATE,
   output logic                    O_BURST_ENABLE,
   output logic                    O_BURST_ORIGIN,
   output logic [1:0]              O_TRIGGER_ORIGIN
);

   trig_sync_if  ext ();
   burst_state_t state;
   logic [15:0]  remaining;
   logic [35:0]  rate_acc;
   logic         rate_tick;
   logic         imm_pending;
   logic         trig_fire;
   logic         gated;
   logic         last_cycle;
   logic         wai_active;
   logic         opc_query_armed;
   logic         opc_cmd_armed;
   logic         ops_idle;
   logic [33:0]  lo_lim;
   logic [33:0]  hi_lim;
   logic [35:0]  next_rate_acc;

   // ----------------------------------------
   // Frequency limit functions
   // ----------------------------------------
   function automatic logic [33:0] freq_ceiling(input logic [2:0] shape, input logic [15:0] cnt);
      logic [33:0] band;
      band = FREQ_STEP_BAND * 34'(cnt);
      if (shape == SHAPE_TRIANGLE || shape == SHAPE_RAMP) begin
         freq_ceiling = FREQ_MAX_TRI;
      end else if (cnt >= COUNT_FULL_BAND) begin
         freq_ceiling = FREQ_MAX_STD;
      end else begin
         freq_ceiling = band;
      end
   endfunction

   function automatic logic [33:0] freq_floor(input logic [15:0] cnt);
      logic [33:0] by_count;
      by_count = 34'(cnt) << SECONDS_SHIFT;
      freq_floor = (by_count > FREQ_MIN) ? by_count : FREQ_MIN;
   endfunction

   assign lo_lim = freq_floor(O_CYCLES_PER_BURST);
   assign hi_lim = freq_ceiling(I_CARRIER_SHAPE, O_CYCLES_PER_BURST);

   // ----------------------------------------
   // External trigger and gate input
   // ----------------------------------------
   trig_input_sync u_sync (
      .i_clk    (I_CLK),
      .i_arst_n (I_ARST_N),
      .i_pin    (I_EXT_TRIG),
      .sync     (ext.src)
   );

   // ----------------------------------------
   // Settings
   // ----------------------------------------
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_CYCLES_PER_BURST     <= COUNT_DEFAULT;
         O_START_PHASE          <= PHASE_DEFAULT;
         O_INTERNAL_REPEAT_RATE <= RATE_DEFAULT;
         O_BURST_ORIGIN         <= ORIGIN_INT;       // see RULE13 RULE22
         O_BURST_ENABLE         <= ENABLE_DEFAULT;   // see RULE22
      end else if (I_CFG_WRITE) begin
         if (I_CYCLES_PER_BURST_SETTING < COUNT_MIN) begin
            O_CYCLES_PER_BURST <= COUNT_MIN;                  // see RULE1
         end else if (I_CYCLES_PER_BURST_SETTING > COUNT_MAX) begin
            O_CYCLES_PER_BURST <= COUNT_MAX;                  // see RULE1
         end else begin
            O_CYCLES_PER_BURST <= I_CYCLES_PER_BURST_SETTING;
         end
         if (I_START_PHASE_SETTING > PHASE_MAX) begin
            O_START_PHASE <= PHASE_MAX;                       // see RULE6
         end else if (I_START_PHASE_SETTING < PHASE_MIN) begin
            O_START_PHASE <= PHASE_MIN;                       // see RULE6
         end else begin
            O_START_PHASE <= I_START_PHASE_SETTING;
         end
         if (I_INTERNAL_REPEAT_RATE_SETTING < RATE_MIN) begin
            O_INTERNAL_REPEAT_RATE <= RATE_MIN;               // see RULE8
         end else if (I_INTERNAL_REPEAT_RATE_SETTING > RATE_MAX) begin
            O_INTERNAL_REPEAT_RATE <= RATE_MAX;               // see RULE8
         end else begin
            O_INTERNAL_REPEAT_RATE <= I_INTERNAL_REPEAT_RATE_SETTING;
         end
         O_BURST_ORIGIN <= I_BURST_ORIGIN_SELECT;             // see RULE13
         O_BURST_ENABLE <= I_BURST_ENABLE_SETTING;            // see RULE21
      end
   end

   // Setup command overrides a same-cycle write
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_TRIGGER_ORIGIN <= TRIG_IMM;                        // see RULE16
      end else if (I_APPLY_STB) begin
         O_TRIGGER_ORIGIN <= TRIG_IMM;                        // see RULE16
      end else if (I_CFG_WRITE && I_TRIGGER_ORIGIN_SELECT <= TRIG_BUS) begin
         O_TRIGGER_ORIGIN <= I_TRIGGER_ORIGIN_SELECT;
      end
   end

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_OTHER_MOD_OFF <= 1'b0;
      end else begin
         O_OTHER_MOD_OFF <= I_CFG_WRITE && I_BURST_ENABLE_SETTING && !O_BURST_ENABLE;  // see RULE14
      end
   end

   // ----------------------------------------
   // Carrier frequency clamp
   // ----------------------------------------
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_CARRIER_FREQ      <= FREQ_DEFAULT;
         O_SETTINGS_CONFLICT <= 1'b0;
      end else begin
         O_SETTINGS_CONFLICT <= 1'b0;
         if (I_FREQ_REQ_STB) begin
            if (I_FREQ_REQ > hi_lim) begin
               O_CARRIER_FREQ      <= hi_lim;                 // see RULE2 RULE3 RULE5
               O_SETTINGS_CONFLICT <= I_FREQ_REQ_REMOTE;      // see RULE3
            end else if (I_FREQ_REQ < FREQ_MIN) begin
               O_CARRIER_FREQ <= lo_lim;                      // see RULE5
            end else if (I_FREQ_REQ <= FREQ_LOW_REGION && I_FREQ_REQ < lo_lim) begin
               O_CARRIER_FREQ      <= lo_lim;                 // see RULE4
               O_SETTINGS_CONFLICT <= I_FREQ_REQ_REMOTE;      // see RULE4
            end else begin
               O_CARRIER_FREQ <= I_FREQ_REQ;
            end
         end
      end
   end

   // ----------------------------------------
   // Internal repeat timer
   // ----------------------------------------
   assign next_rate_acc = rate_acc + 36'(O_INTERNAL_REPEAT_RATE);

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         rate_acc  <= '0;
         rate_tick <= 1'b0;
      end else if (next_rate_acc >= CLK_MHZ_UNITS) begin
         rate_acc  <= next_rate_acc - CLK_MHZ_UNITS;          // see RULE8
         rate_tick <= 1'b1;
      end else begin
         rate_acc  <= next_rate_acc;
         rate_tick <= 1'b0;
      end
   end

   // ----------------------------------------
   // Trigger selection
   // ----------------------------------------
   assign gated = O_BURST_ENABLE && (O_BURST_ORIGIN == ORIGIN_EXT);    // see RULE12
   assign last_cycle = (state == ST_RUN) && I_CARRIER_WRAP && (remaining == COUNT_MIN);

   // Ticks during a burst are kept, so a fast rate repeats back to back
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         imm_pending <= 1'b0;
      end else if (!O_BURST_ENABLE || gated || O_TRIGGER_ORIGIN != TRIG_IMM) begin
         imm_pending <= 1'b0;                                 // see RULE9
      end else if (rate_tick) begin
         imm_pending <= 1'b1;                                 // see RULE10
      end else if (trig_fire) begin
         imm_pending <= 1'b0;
      end
   end

   always_comb begin
      trig_fire = 1'b0;
      if (O_BURST_ENABLE && !gated && (state == ST_IDLE || last_cycle)) begin
         case (O_TRIGGER_ORIGIN)
            TRIG_IMM: trig_fire = imm_pending;                // see RULE10
            TRIG_EXT: trig_fire = ext.rise;                   // see RULE17 RULE23
            TRIG_BUS: trig_fire = I_BUS_TRIGGER;              // see RULE18
            default:  trig_fire = 1'b0;
         endcase
      end
   end

   // ----------------------------------------
   // Burst sequencer
   // ----------------------------------------
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         state        <= ST_IDLE;
         remaining    <= COUNT_DEFAULT;
         O_PHASE_LOAD <= 1'b0;
         O_BURST_DONE <= 1'b0;
      end else begin
         O_PHASE_LOAD <= 1'b0;
         O_BURST_DONE <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (trig_fire) begin
                  state        <= ST_RUN;
                  remaining    <= O_CYCLES_PER_BURST;
                  O_PHASE_LOAD <= 1'b1;                       // see RULE6
               end
            end
            ST_RUN: begin
               if (!O_BURST_ENABLE || gated) begin
                  state <= ST_IDLE;
               end else if (last_cycle) begin
                  O_BURST_DONE <= 1'b1;                       // see RULE15
                  if (trig_fire) begin
                     remaining    <= O_CYCLES_PER_BURST;
                     O_PHASE_LOAD <= 1'b1;
                  end else begin
                     state <= ST_IDLE;
                  end
               end else if (I_CARRIER_WRAP) begin
                  remaining <= remaining - COUNT_MIN;         // see RULE15
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Output gating and indications
   // ----------------------------------------
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_CARRIER_ON              <= 1'b0;
         O_TRIG_WAIT               <= 1'b0;
         O_PHASE_FROM_FIRST_SAMPLE <= 1'b0;
      end else begin
         if (!O_BURST_ENABLE) begin
            O_CARRIER_ON <= 1'b1;
         end else if (gated) begin
            O_CARRIER_ON <= ext.level;                        // see RULE11
         end else begin
            O_CARRIER_ON <= trig_fire || (state == ST_RUN && !last_cycle);  // see RULE15
         end
         O_TRIG_WAIT <= O_BURST_ENABLE && !gated && O_TRIGGER_ORIGIN == TRIG_EXT
                        && state == ST_IDLE && !trig_fire;    // see RULE17
         O_PHASE_FROM_FIRST_SAMPLE <= (I_CARRIER_SHAPE == SHAPE_ARB);  // see RULE7
      end
   end

   // ----------------------------------------
   // Command synchronisation
   // ----------------------------------------
   assign ops_idle = (state == ST_IDLE) && !trig_fire && !imm_pending;

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         wai_active <= 1'b0;
         O_CMD_HOLD <= 1'b0;
      end else begin
         if (I_WAI_STB) begin
            wai_active <= 1'b1;                               // see RULE19
         end else if (ops_idle || O_TRIGGER_ORIGIN == TRIG_IMM) begin
            wai_active <= 1'b0;
         end
         O_CMD_HOLD <= I_WAI_STB || (wai_active && !(ops_idle || O_TRIGGER_ORIGIN == TRIG_IMM));
      end
   end

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         opc_query_armed <= 1'b0;
         opc_cmd_armed   <= 1'b0;
         O_OPC_REPLY     <= 1'b0;
         O_OPC_FLAG      <= 1'b0;
      end else begin
         O_OPC_REPLY <= opc_query_armed && ops_idle;          // see RULE20
         if (I_OPC_QUERY_STB) begin
            opc_query_armed <= 1'b1;
         end else if (ops_idle) begin
            opc_query_armed <= 1'b0;
         end
         if (I_OPC_CMD_STB) begin
            opc_cmd_armed <= 1'b1;
         end else if (ops_idle) begin
            opc_cmd_armed <= 1'b0;
         end
         if (opc_cmd_armed && ops_idle) begin
            O_OPC_FLAG <= 1'b1;                               // see RULE20
         end else if (I_OPC_FLAG_CLEAR) begin
            O_OPC_FLAG <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_ARST_N);

   count_range_a: assert property (O_CYCLES_PER_BURST >= COUNT_MIN && O_CYCLES_PER_BURST <= COUNT_MAX)  // see RULE1
      else $error("burst count out of range");
   freq_ceiling_a: assert property (I_FREQ_REQ_STB ##1 1'b1 |-> O_CARRIER_FREQ <= $past(hi_lim))  // see RULE3
      else $error("carrier above allowed ceiling");
   conflict_cause_a: assert property (O_SETTINGS_CONFLICT |-> $past(I_FREQ_REQ_STB && I_FREQ_REQ_REMOTE))  // see RULE4
      else $error("conflict without remote request");
   phase_range_a: assert property (O_START_PHASE <= PHASE_MAX && O_START_PHASE >= PHASE_MIN)  // see RULE6
      else $error("start phase out of range");
   gate_follow_a: assert property (gated && $stable(gated) |=> O_CARRIER_ON == $past(ext.level))  // see RULE11
      else $error("gated output not following gate");
   apply_imm_a: assert property (I_APPLY_STB |=> O_TRIGGER_ORIGIN == TRIG_IMM)  // see RULE16
      else $error("setup did not force immediate");
   burst_start_a: assert property (state == ST_IDLE && trig_fire |=> state == ST_RUN && O_PHASE_LOAD)  // see RULE15
      else $error("trigger did not start burst");
   burst_end_a: assert property (last_cycle && !trig_fire && O_BURST_ENABLE && !gated  // see RULE15
                                 |=> O_BURST_DONE && state == ST_IDLE && !O_CARRIER_ON)
      else $error("burst did not end after count");
   ext_single_a: assert property (trig_fire |-> O_TRIGGER_ORIGIN != TRIG_EXT || ext.rise)  // see RULE17
      else $error("external burst without rising edge");
   opc_flag_a: assert property (opc_cmd_armed && ops_idle |=> O_OPC_FLAG)  // see RULE20
      else $error("completion flag not set");

   ext_burst_c: cover property (O_TRIGGER_ORIGIN == TRIG_EXT && ext.rise ##1 state == ST_RUN);
   back_to_back_c: cover property (last_cycle && trig_fire);
   gated_on_c: cover property (gated && O_CARRIER_ON);
   conflict_c: cover property (O_SETTINGS_CONFLICT);

endmodule

// ### bench/burst_far_side_model.sv
module burst_far_side_model (
   input  wire logic i_clk,
   input  wire logic i_carrier_on,
   input  wire logic i_level,
   output logic      o_wrap = 1'b0,
   output logic      o_ext_trig
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] div = 2'h0;
   // Synthesiser stand-in: a wrap every fourth cycle while on
   always @(posedge i_clk) begin
      div <= i_carrier_on ? div + 2'h1 : 2'h0;
      o_wrap <= i_carrier_on && (div == 2'h3);
   end
   assign o_ext_trig = i_level;
endmodule

// ### bench/burst_modulation_controller_tb.sv
module burst_modulation_controller_tb
   import burst_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic I_CLK = 0, I_ARST_N = 0, I_CFG_WRITE = 0, I_BURST_ORIGIN_SELECT = 0, I_BURST_ENABLE_SETTING = 1;
   logic I_APPLY_STB = 0, I_FREQ_REQ_STB = 0, I_FREQ_REQ_REMOTE = 0, I_BUS_TRIGGER = 0, I_WAI_STB = 0;
   logic I_OPC_QUERY_STB = 0, I_OPC_CMD_STB = 0, I_OPC_FLAG_CLEAR = 0, I_CARRIER_WRAP, I_EXT_TRIG, ext_level = 0;
   logic [15:0] I_CYCLES_PER_BURST_SETTING = 16'h0001, O_CYCLES_PER_BURST;
   logic signed [19:0] I_START_PHASE_SETTING = 20'sh00000, O_START_PHASE;
   logic [25:0] I_INTERNAL_REPEAT_RATE_SETTING = 26'h00186A0, O_INTERNAL_REPEAT_RATE;
   logic [1:0] I_TRIGGER_ORIGIN_SELECT = 2'h0, O_TRIGGER_ORIGIN;
   logic [33:0] I_FREQ_REQ = 34'h0000F4240, O_CARRIER_FREQ;
   logic [2:0] I_CARRIER_SHAPE = 3'h0;
   logic O_CARRIER_ON, O_PHASE_LOAD, O_PHASE_FROM_FIRST_SAMPLE, O_SETTINGS_CONFLICT, O_OTHER_MOD_OFF, O_TRIG_WAIT;
   logic O_BURST_DONE, O_CMD_HOLD, O_OPC_REPLY, O_OPC_FLAG, O_BURST_ENABLE, O_BURST_ORIGIN;
   int num_errors = 0, n_compared = 0, nw = 0, k = 0;
   int unsigned cnt = 1;
   burst_modulation_controller dut (.*);
   burst_far_side_model far (.i_clk(I_CLK), .i_carrier_on(O_CARRIER_ON), .i_level(ext_level),
                             .o_wrap(I_CARRIER_WRAP), .o_ext_trig(I_EXT_TRIG));
   initial forever #10 I_CLK = ~I_CLK;
   // Wraps seen since the last burst start
   always @(posedge I_CLK) begin
      if (O_PHASE_LOAD === 1'b1) nw <= 0;
      else if (I_CARRIER_WRAP === 1'b1) nw <= nw + 1;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic conclude;
      if (num_errors == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick;
      @(posedge I_CLK);
      #1;
   endtask
   task automatic wait_for(input int w, input int lim);
      for (k = 0; k < lim; k++) begin
         if ((w == 0 ? O_BURST_DONE : w == 1 ? O_OPC_REPLY : w == 2 ? O_PHASE_LOAD : O_OPC_FLAG) === 1'b1) break;
         tick;
      end
      if (k == lim) begin
         chk(34'h0, 34'h1);
         conclude;
      end
   endtask
   function automatic logic [34:0] exp_freq(input logic [33:0] f, input logic rem);
      logic [33:0] ceil;
      ceil = (I_CARRIER_SHAPE == SHAPE_TRIANGLE || I_CARRIER_SHAPE == SHAPE_RAMP) ? FREQ_MAX_TRI
           : FREQ_STEP_BAND * 34'(cnt > COUNT_FULL_BAND ? COUNT_FULL_BAND : cnt);
      if (f > ceil) return {rem, ceil};
      if (f < FREQ_MIN) return {1'b0, (34'(cnt * 2) > FREQ_MIN) ? 34'(cnt * 2) : FREQ_MIN};
      if (f <= FREQ_LOW_REGION && f < 34'(cnt * 2)) return {rem, 34'(cnt * 2)};
      return {1'b0, f};
   endfunction
   task automatic cfg(input logic [15:0] c, input logic signed [19:0] p, input logic [25:0] r,
                      input logic o, input logic [1:0] t, input logic e);
      tick;
      I_CYCLES_PER_BURST_SETTING = c;
      I_START_PHASE_SETTING = p;
      I_INTERNAL_REPEAT_RATE_SETTING = r;
      I_BURST_ORIGIN_SELECT = o;
      I_TRIGGER_ORIGIN_SELECT = t;
      I_BURST_ENABLE_SETTING = e;
      I_CFG_WRITE = 1;
      tick;
      I_CFG_WRITE = 0;
      cnt = c < COUNT_MIN ? COUNT_MIN : c > COUNT_MAX ? COUNT_MAX : c;
      chk(O_CYCLES_PER_BURST, cnt);
      chk(O_START_PHASE, p > PHASE_MAX ? PHASE_MAX : p < PHASE_MIN ? PHASE_MIN : p);
      chk(O_INTERNAL_REPEAT_RATE, r < RATE_MIN ? RATE_MIN : r > RATE_MAX ? RATE_MAX : r);
      chk({O_BURST_ORIGIN, O_BURST_ENABLE, O_TRIGGER_ORIGIN}, {o, e, t});
   endtask
   task automatic freq(input logic [33:0] f, input logic rem);
      logic [34:0] e;
      e = exp_freq(f, rem);
      tick;
      I_FREQ_REQ = f;
      I_FREQ_REQ_REMOTE = rem;
      I_FREQ_REQ_STB = 1;
      tick;
      I_FREQ_REQ_STB = 0;
      chk(O_CARRIER_FREQ, e[33:0]);
      chk(O_SETTINGS_CONFLICT, e[34]);
   endtask
   task automatic bus_burst(input logic signed [19:0] p);
      I_BUS_TRIGGER = 1;
      tick;
      I_BUS_TRIGGER = 0;
      I_WAI_STB = 1;
      chk(O_PHASE_LOAD, 1);
      chk(O_START_PHASE, p);
      chk(O_PHASE_FROM_FIRST_SAMPLE, I_CARRIER_SHAPE == SHAPE_ARB);
      tick;
      I_WAI_STB = 0;
      I_OPC_QUERY_STB = 1;
      chk(O_CMD_HOLD, 1);
      tick;
      I_OPC_QUERY_STB = 0;
      wait_for(0, 2000);
      chk(nw, cnt);
      chk(O_CARRIER_ON, 0);
      wait_for(1, 3);
      chk(O_CMD_HOLD, 0);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(38));
      repeat (8) @(posedge I_CLK);
      #1 I_ARST_N = 1;
      chk(O_CYCLES_PER_BURST, COUNT_DEFAULT);
      chk(O_INTERNAL_REPEAT_RATE, RATE_DEFAULT);
      chk(O_START_PHASE, PHASE_DEFAULT);
      chk({O_BURST_ORIGIN, O_TRIGGER_ORIGIN, O_BURST_ENABLE}, {ORIGIN_INT, TRIG_IMM, ENABLE_DEFAULT});
      chk(O_CARRIER_FREQ, FREQ_DEFAULT);
      cfg(16'h0000, 20'sh7FFFF, 26'h0000000, ORIGIN_INT, TRIG_BUS, 1'b1);
      cfg(16'hFFFF, -20'sh7FFFF, 26'h3FFFFFF, ORIGIN_INT, TRIG_BUS, 1'b1);
      cfg(16'h0002, 20'sh00000, RATE_DEFAULT, ORIGIN_INT, TRIG_BUS, 1'b1);
      repeat (10) tick;
      freq(34'h0B2D05E00, 1'b1);
      I_CARRIER_SHAPE = SHAPE_TRIANGLE;
      freq(34'h00BEBC200, 1'b1);
      cfg(16'h0064, 20'sh00000, RATE_DEFAULT, ORIGIN_INT, TRIG_BUS, 1'b1);
      freq(34'h000000032, 1'b1);
      freq(34'h000000032, 1'b0);
      freq(34'h000000005, 1'b1);
      for (int i = 0; i < 16; i++) begin
         I_CARRIER_SHAPE = 3'($urandom_range(0, 4));
         cfg(16'(($urandom & 1) ? $urandom_range(1, 6) : $urandom_range(1, 50000)),
             20'($urandom_range(0, 720000)) - PHASE_MAX, 26'($urandom_range(10, 50000000)),
             ORIGIN_INT, TRIG_BUS, 1'b1);
         freq(($urandom & 2) ? 34'($urandom_range(10, 200000)) : 34'($urandom) + 34'($urandom), 1'($urandom));
         if (cnt < 7) bus_burst(I_START_PHASE_SETTING);
      end
      cfg(16'h0002, 20'sh01000, RATE_DEFAULT, ORIGIN_INT, TRIG_EXT, 1'b1);
      tick;
      chk(O_TRIG_WAIT, 1);
      ext_level = 1;
      wait_for(0, 400);
      chk(nw, cnt);
      ext_level = 0;
      cfg(16'h0002, 20'sh00000, RATE_DEFAULT, ORIGIN_EXT, TRIG_BUS, 1'b1);
      ext_level = 1;
      repeat (6) tick;
      chk(O_CARRIER_ON, 1);
      ext_level = 0;
      repeat (6) tick;
      chk(O_CARRIER_ON, 0);
      cfg(16'h0002, 20'sh00000, RATE_DEFAULT, ORIGIN_INT, TRIG_BUS, 1'b0);
      ext_level = 1;
      repeat (6) tick;
      chk(O_CARRIER_ON, 1);
      cfg(16'h0002, 20'sh00000, RATE_DEFAULT, ORIGIN_INT, TRIG_BUS, 1'b1);
      chk(O_OTHER_MOD_OFF, 1);
      repeat (6) tick;
      chk(O_CARRIER_ON, 0);
      ext_level = 0;
      I_OPC_CMD_STB = 1;
      tick;
      I_OPC_CMD_STB = 0;
      wait_for(3, 4);
      I_OPC_FLAG_CLEAR = 1;
      tick;
      I_OPC_FLAG_CLEAR = 0;
      chk(O_OPC_FLAG, 0);
      cfg(16'h012C, 20'sh00000, RATE_MAX, ORIGIN_INT, TRIG_BUS, 1'b1);
      I_APPLY_STB = 1;
      tick;
      I_APPLY_STB = 0;
      chk(O_TRIGGER_ORIGIN, TRIG_IMM);
      wait_for(0, 3000);
      wait_for(2, 3);
      chk(O_INTERNAL_REPEAT_RATE, RATE_MAX);
      conclude;
   end
endmodule
